// [design/usbsr_defs.svh]
// Constants for the USB suspend and resume supervisor.
// Assumes one 100 MHz clock; included by bare name.
`ifndef USBSR_DEFS_SVH
`define USBSR_DEFS_SVH

// ----------------------------------------
// Pin counts and timing
// ----------------------------------------
`define USBSR_NUM_PINS     11
`define USBSR_CLK_NS       10
`define USBSR_WAKE_NS      2000
`define USBSR_WAKE_CYC     (`USBSR_WAKE_NS / `USBSR_CLK_NS)

`endif

// [design/usbsr_pkg.sv]
// Types for the USB suspend and resume supervisor.
// Assumes the defs header supplies pin counts and timing; the state encodings are set here.
package usbsr_pkg;

	// ----------------------------------------
	// Supervisor states
	// ----------------------------------------
	typedef enum logic [3:0] {
		USBSR_ST_INIT    = 4'h1,
		USBSR_ST_ACTIVE  = 4'h2,
		USBSR_ST_SUSPEND = 4'h4,
		USBSR_ST_WAKE    = 4'h8
	} usbsr_state_t;

endpackage : usbsr_pkg

// [design/usbsr_top.sv]
// Suspend and resume supervisor for a full-speed USB function.
// Assumes the USB core flags bus events as one-cycle pulses on clk,
// and that configuration bits are steady once cfg_loaded rises.
//
// Function
// - Suspend signalling from the host puts the device in suspend.
// - Entering suspend asserts both suspend indicators.
// - After reset the indicators stay asserted until configured and enumerated.
// - The active-high indicator is one in suspend and zero in normal mode.
// - Outside reset the second indicator is the complement of the first; in reset both are one.
// - Detected or self-generated resume signalling ends suspend.
// - A USB bus reset or a device reset ends suspend.
// - Enabled wakeup pins differing from their wake_match level end suspend.
// - During reset both indicator pins float with only a weak pull-up.
// - Each general-purpose pin can be a wakeup source with its own match level.
// - A mismatching enabled wakeup pin in suspend sends remote wakeup upstream when rwake_allowed is set; otherwise it ends suspend directly.
// - With remote wakeup enabled the host answers with resume, ending suspend.
// - Suspend-time pin level and drive type come from configuration on entry.
`timescale 1ns/1ps
`include "usbsr_defs.svh"
`default_nettype none

module usbsr_top
	import usbsr_pkg::*;
#(
	parameter int NPINS    = `USBSR_NUM_PINS,
	parameter int WAKE_CYC = `USBSR_WAKE_CYC
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// Configuration and enumeration status
	input  wire logic             cfg_loaded,
	input  wire logic             enum_done,
	input  wire logic [NPINS-1:0] wake_en,
	input  wire logic [NPINS-1:0] wake_match,
	input  wire logic [NPINS-1:0] susp_level,
	input  wire logic [NPINS-1:0] susp_opendrain,
	// Bus events from the USB core, one-cycle pulses; rwake_allowed is a level
	input  wire logic             bus_suspend,
	input  wire logic             bus_resume,
	input  wire logic             bus_reset,
	input  wire logic             rwake_allowed,
	// General-purpose pins, asynchronous
	input  wire logic [NPINS-1:0] gp_pin_in,
	// Remote wakeup request to the transceiver
	output var  logic             rwake_drive,
	// Suspend indicators, enables low while driving
	output var  logic             susp_out,
	output var  logic             susp_oe_n,
	output var  logic             susp_n_out,
	output var  logic             susp_n_oe_n,
	// Suspend-time pin overrides
	output var  logic             pin_ovr,
	output var  logic [NPINS-1:0] pin_ovr_level,
	output var  logic [NPINS-1:0] pin_ovr_od,
	// Register port
	input  wire logic [1:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output var  logic [7:0]       reg_rdata,
	output var  logic             irq
);

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [1:0] A_STATUS = 2'h0;
	localparam logic [1:0] A_MASK   = 2'h1;
	localparam logic [1:0] A_STATE  = 2'h2;
	localparam int         CW       = $clog2(WAKE_CYC + 1);

	usbsr_state_t     state_reg;
	logic [NPINS-1:0] s1_reg;
	logic [NPINS-1:0] s2_reg;
	logic [NPINS-1:0] s3_reg;
	logic [NPINS-1:0] pins_reg;
	logic             mismatch;
	logic [CW-1:0]    wcnt_reg;
	logic             in_susp;
	logic [2:0]       ev_set;
	logic [2:0]       stat_reg;
	logic [2:0]       mask_reg;
	logic             rst_seen_reg;

	// ----------------------------------------
	// Wakeup pin synchroniser
	// ----------------------------------------
	// three stage sync
	always_ff @(posedge clk) begin
		s1_reg <= gp_pin_in;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	// Per-pin filter: change accepted when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++) begin : g_pin
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					pins_reg[gi] <= 1'b0;
				end else if (s2_reg[gi] == s3_reg[gi]) begin
					pins_reg[gi] <= s3_reg[gi];
				end
			end
		end
	endgenerate

	assign mismatch = |(wake_en & (pins_reg ^ wake_match));
	assign in_susp  = (state_reg == USBSR_ST_SUSPEND) ||
	                  (state_reg == USBSR_ST_WAKE);

	// ----------------------------------------
	// Supervisor state machine
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= USBSR_ST_INIT;
		end else begin
			case (state_reg)
				USBSR_ST_INIT: begin
					if (cfg_loaded && enum_done) begin
						state_reg <= USBSR_ST_ACTIVE;
					end
				end
				USBSR_ST_ACTIVE: begin
					if (bus_suspend) begin
						state_reg <= USBSR_ST_SUSPEND;
					end
				end
				USBSR_ST_SUSPEND: begin
					if (bus_resume || bus_reset) begin
						state_reg <= USBSR_ST_ACTIVE;
					end else if (mismatch && rwake_allowed) begin
						state_reg <= USBSR_ST_WAKE;
					end else if (mismatch) begin
						state_reg <= USBSR_ST_ACTIVE;
					end
				end
				USBSR_ST_WAKE: begin
					if (bus_resume || bus_reset ||
					    wcnt_reg == CW'(WAKE_CYC)) begin
						state_reg <= USBSR_ST_ACTIVE;
					end
				end
				default: state_reg <= USBSR_ST_INIT;
			endcase
		end
	end

	// Remote wakeup signalling duration
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wcnt_reg <= '0;
		end else if (state_reg == USBSR_ST_WAKE) begin
			wcnt_reg <= wcnt_reg + CW'(1);
		end else begin
			wcnt_reg <= '0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rwake_drive <= 1'b0;
		end else begin
			rwake_drive <= (state_reg == USBSR_ST_WAKE) &&
			               (wcnt_reg < CW'(WAKE_CYC - 1)) &&
			               !bus_resume && !bus_reset;
		end
	end

	// ----------------------------------------
	// Suspend indicators
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			susp_out    <= 1'b1;
			susp_n_out  <= 1'b1;
			susp_oe_n   <= 1'b1;
			susp_n_oe_n <= 1'b1;
		end else begin
			susp_out    <= (state_reg != USBSR_ST_ACTIVE);
			susp_n_out  <= (state_reg == USBSR_ST_ACTIVE);
			susp_oe_n   <= 1'b0;
			susp_n_oe_n <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_ovr       <= 1'b0;
			pin_ovr_level <= '0;
			pin_ovr_od    <= '0;
		end else begin
			pin_ovr <= in_susp;
			if (state_reg == USBSR_ST_ACTIVE && bus_suspend) begin
				pin_ovr_level <= susp_level;
				pin_ovr_od    <= susp_opendrain;
			end
		end
	end

	// ----------------------------------------
	// Interrupt status, read clears
	// ----------------------------------------
	// Bit 0 suspend entered, bit 1 left suspend, bit 2 wakeup sent
	assign ev_set[0] = (state_reg == USBSR_ST_ACTIVE) && bus_suspend;
	assign ev_set[1] = in_susp && !sys_rst &&
	                   (state_reg == USBSR_ST_SUSPEND ?
	                    (bus_resume || bus_reset || (mismatch &&
	                     !rwake_allowed)) :
	                    (bus_resume || bus_reset ||
	                     wcnt_reg == CW'(WAKE_CYC)));
	assign ev_set[2] = (state_reg == USBSR_ST_SUSPEND) && mismatch &&
	                   rwake_allowed && !bus_resume && !bus_reset;

	// Set wins over the read clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stat_reg <= '0;
		end else if (reg_rd && reg_addr == A_STATUS) begin
			stat_reg <= ev_set;
		end else begin
			stat_reg <= stat_reg | ev_set;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mask_reg <= '0;
		end else if (reg_wr && reg_addr == A_MASK) begin
			mask_reg <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_reg & mask_reg);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				A_STATUS: reg_rdata <= {5'h00, stat_reg};
				A_MASK:   reg_rdata <= {5'h00, mask_reg};
				A_STATE:  reg_rdata <= {4'h0, state_reg};
				default:  reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	always_ff @(posedge clk) begin
		rst_seen_reg <= sys_rst;
	end

	sequence s_suspend_req;
		state_reg == USBSR_ST_ACTIVE && bus_suspend;
	endsequence

	sequence s_wake_req;
		state_reg == USBSR_ST_SUSPEND && mismatch && rwake_allowed &&
		!bus_resume && !bus_reset;
	endsequence

	suspend_entry_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		s_suspend_req |=> state_reg == USBSR_ST_SUSPEND ##1 susp_out)
		else $error("suspend not entered");
	both_assert_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		s_suspend_req |=> ##1 susp_out && !susp_n_out && !susp_oe_n)
		else $error("indicators not asserted");
	init_hold_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!(cfg_loaded && enum_done) && state_reg == USBSR_ST_INIT
		|=> ##1 susp_out)
		else $error("indicator dropped before ready");
	active_low_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		$past(state_reg) == USBSR_ST_ACTIVE && !$past(sys_rst)
		|-> !susp_out)
		else $error("indicator high in normal mode");
	complement_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!rst_seen_reg |-> susp_n_out == !susp_out)
		else $error("indicators not complementary");
	resume_exit_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		state_reg == USBSR_ST_SUSPEND && (bus_resume || bus_reset)
		|=> state_reg == USBSR_ST_ACTIVE)
		else $error("resume did not exit");
	reset_release_a: assert property (
		@(posedge clk)
		sys_rst |=> susp_oe_n && susp_n_oe_n)
		else $error("indicators driven in reset");
	// A host resume in the first wake cycle legally cancels the request
	wake_start_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		s_wake_req |=> (bus_resume || bus_reset) or ##1 rwake_drive)
		else $error("remote wakeup not sent");
	wake_bound_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		state_reg == USBSR_ST_WAKE && bus_resume
		|=> state_reg == USBSR_ST_ACTIVE ##1 !rwake_drive)
		else $error("host resume ignored");
	mismatch_exit_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		state_reg == USBSR_ST_SUSPEND && mismatch && !rwake_allowed
		|=> state_reg == USBSR_ST_ACTIVE)
		else $error("mismatch did not exit");
	ovr_capture_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		s_suspend_req |=> pin_ovr_od == $past(susp_opendrain))
		else $error("suspend drive not captured");
	ovr_level_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		s_suspend_req |=> pin_ovr_level == $past(susp_level))
		else $error("suspend level not captured");
	bus_reset_exit_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		in_susp && bus_reset
		|=> state_reg == USBSR_ST_ACTIVE)
		else $error("bus reset did not exit");
	wake_timeout_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		state_reg == USBSR_ST_WAKE && wcnt_reg == CW'(WAKE_CYC)
		|=> state_reg == USBSR_ST_ACTIVE)
		else $error("wakeup did not end");

endmodule : usbsr_top

`default_nettype wire

// [dv/usbsr_host_model.sv]
// Host side of the USB link: bus event pulses and wakeup answers.
// Assumes the bench asks for events through cmd, one cycle each.
`timescale 1ns/1ps
`default_nettype none

module usbsr_host_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Bench requests and host policy
	input  wire logic [1:0] cmd,
	input  wire logic       answer_en,
	input  wire logic [2:0] answer_dly,
	input  wire logic       rwake_allowed,
	input  wire logic       rwake_drive,
	// Bus events towards the device
	output var  logic       bus_suspend,
	output var  logic       bus_resume,
	output var  logic       bus_reset
);
	logic [3:0] cnt_reg;

	// Answer delay counts wakeup cycles seen
	always_ff @(posedge clk) begin
		if (sys_rst || !rwake_drive)
			cnt_reg <= 4'h0;
		else
			cnt_reg <= cnt_reg + 4'h1;
	end

	always_ff @(posedge clk) begin
		bus_suspend <= !sys_rst && cmd == 2'h1;
		bus_reset   <= !sys_rst && cmd == 2'h3;
		bus_resume  <= !sys_rst && (cmd == 2'h2 || (answer_en &&
			rwake_allowed && rwake_drive &&
			cnt_reg == {1'b0, answer_dly}));
	end
endmodule : usbsr_host_model
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the suspend and resume supervisor.
// Assumes the host model file; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        clk = 1'b0;
	logic        sys_rst, cfg_loaded, enum_done, rwake_allowed;
	logic [10:0] wake_en, wake_match, susp_level, susp_opendrain;
	logic [10:0] gp_pin_in, pin_ovr_level, pin_ovr_od;
	logic        bus_suspend, bus_resume, bus_reset, rwake_drive;
	logic        susp_out, susp_oe_n, susp_n_out, susp_n_oe_n;
	logic        pin_ovr, irq, reg_wr, reg_rd, answer_en;
	logic [1:0]  reg_addr, cmd;
	logic [2:0]  answer_dly;
	logic [7:0]  reg_wdata, reg_rdata, rd;
	int          err_total = 0;
	int          samples_checked = 0;
	logic [10:0] hi_cnt;
	localparam int WAKE_CYC = 8;

	always #5 clk = ~clk;

	usbsr_top #(.WAKE_CYC(WAKE_CYC)) dut (.clk, .sys_rst, .cfg_loaded,
		.enum_done, .wake_en, .wake_match, .susp_level, .susp_opendrain,
		.bus_suspend, .bus_resume, .bus_reset, .rwake_allowed, .gp_pin_in,
		.rwake_drive, .susp_out, .susp_oe_n, .susp_n_out, .susp_n_oe_n,
		.pin_ovr, .pin_ovr_level, .pin_ovr_od, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .irq);

	usbsr_host_model host_m (.clk, .sys_rst, .cmd, .answer_en,
		.answer_dly, .rwake_allowed, .rwake_drive, .bus_suspend,
		.bus_resume, .bus_reset);

	task automatic chk(string n, logic [10:0] e, logic [10:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic wr(logic [1:0] a, logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rdr(logic [1:0] a);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask : rdr

	task automatic host(logic [1:0] c);
		@(posedge clk);
		cmd <= c;
		@(posedge clk);
		cmd <= 2'h0;
	endtask : host

	task automatic wait_susp(logic v);
		#1;
		for (int i = 0; i < 16 && susp_out !== v; i++)
			@(posedge clk) #1;
	endtask : wait_susp

	task automatic enter;
		// Let the pin synchroniser settle so a stale level cannot end it
		repeat (4) @(posedge clk);
		host(2'h1);
		wait_susp(1'b1);
	endtask : enter

	task automatic t_start;
		repeat (12) @(posedge clk);
		#1 chk("oe", 11'h3, {susp_oe_n, susp_n_oe_n});
		chk("rst lvl", 11'h3, {susp_out, susp_n_out});
		sys_rst <= 1'b0;
		cfg_loaded <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk("init", 11'h4, {susp_out, susp_n_out, susp_oe_n});
		enum_done <= 1'b1;
		wait_susp(1'b0);
		chk("act", 11'h1, {susp_out, susp_n_out});
		rdr(2'h2);
		chk("state", 11'h2, rd);
		rdr(2'h3);
		chk("unmapped", 11'h0, rd);
		rdr(2'h0);
		$display("start done");
	endtask : t_start

	task automatic t_suspend;
		enter();
		chk("susp", 11'h2, {susp_out, susp_n_out});
		chk("ovr", 11'h1, pin_ovr);
		chk("ovr lvl", susp_level, pin_ovr_level);
		chk("ovr od", susp_opendrain, pin_ovr_od);
		chk("irq masked", 11'h0, irq);
		wr(2'h1, 8'h01);
		@(posedge clk) #1 chk("irq", 11'h1, irq);
		rdr(2'h0);
		chk("status", 11'h1, rd);
		@(posedge clk) #1 chk("irq clr", 11'h0, irq);
		host(2'h2);
		wait_susp(1'b0);
		chk("resume", 11'h1, {susp_out, susp_n_out});
		rdr(2'h0);
		chk("left", 11'h2, rd);
		enter();
		host(2'h3);
		wait_susp(1'b0);
		chk("bus rst", 11'h0, susp_out);
		$display("suspend done");
	endtask : t_suspend

	task automatic t_pinwake(logic [2:0] dly);
		answer_dly <= dly;
		rwake_allowed <= 1'b1;
		enter();
		gp_pin_in <= 11'h006;
		repeat (10) @(posedge clk);
		#1 chk("off pin", 11'h2, {susp_out, rwake_drive});
		gp_pin_in <= 11'h007;
		repeat (2) @(posedge clk);
		#1 chk("sync", 11'h0, rwake_drive);
		for (int i = 0; i < 12 && rwake_drive !== 1'b1; i++)
			@(posedge clk) #1;
		chk("rwake", 11'h1, rwake_drive);
		wait_susp(1'b0);
		gp_pin_in <= 11'h002;
		chk("answer", 11'h0, {susp_out, rwake_drive});
		rdr(2'h0);
		chk("sent", 11'h1, rd[2]);
		$display("pin wake done");
	endtask : t_pinwake

	task automatic t_timeout;
		answer_en <= 1'b0;
		rwake_allowed <= 1'b1;
		enter();
		gp_pin_in <= 11'h003;
		for (int i = 0; i < 12 && rwake_drive !== 1'b1; i++)
			@(posedge clk) #1;
		hi_cnt = 11'h000;
		while (rwake_drive === 1'b1 && hi_cnt < 11'h014) begin
			@(posedge clk) #1;
			hi_cnt++;
		end
		chk("rwake len", 11'(WAKE_CYC - 1), hi_cnt);
		wait_susp(1'b0);
		chk("timeout", 11'h1, {susp_out, susp_n_out});
		rdr(2'h0);
		chk("timeout st", 11'h7, rd);
		gp_pin_in <= 11'h002;
		answer_en <= 1'b1;
		$display("timeout done");
	endtask : t_timeout

	task automatic t_direct;
		rwake_allowed <= 1'b0;
		enter();
		gp_pin_in <= 11'h000;
		wait_susp(1'b0);
		gp_pin_in <= 11'h002;
		chk("latch", 11'h0, {susp_out, rwake_drive});
		enter();
		rdr(2'h2);
		chk("asleep", 11'h4, rd);
		enum_done <= 1'b0;
		sys_rst <= 1'b1;
		@(posedge clk) #1;
		chk("dev rst", 11'h3, {susp_oe_n, susp_n_oe_n});
		sys_rst <= 1'b0;
		@(posedge clk) #1;
		chk("re init", 11'h4, {susp_out, susp_n_out, susp_oe_n});
		rdr(2'h2);
		chk("init st", 11'h1, rd);
		enum_done <= 1'b1;
		wait_susp(1'b0);
		chk("re act", 11'h1, {susp_out, susp_n_out});
		$display("direct done");
	endtask : t_direct

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	initial begin
		{sys_rst, answer_en} = 2'h3;
		{cfg_loaded, enum_done, rwake_allowed, reg_wr, reg_rd} = 5'h0;
		{reg_addr, cmd, answer_dly, reg_wdata} = 15'h0;
		{wake_en, wake_match, gp_pin_in} = {11'h003, 11'h002, 11'h002};
		{susp_level, susp_opendrain} = {11'h5a5, 11'h0f0};
		t_start();
		t_suspend();
		t_pinwake(3'h0);
		t_pinwake(3'h3);
		t_timeout();
		t_direct();
		print_verdict();
	end

	// Run needs under a thousand cycles
	initial begin
		#20000;
		err_total++;
		print_verdict();
	end
endmodule : tb
`default_nettype wire
